// [dv/disc_cpu_model.sv]
`timescale 1ns/1ps
module disc_cpu_model (
   input  wire logic  clk_in,
   input  wire logic  rst_in,
   input  wire logic  set_in,
   input  wire logic  clr_in,
   input  wire logic  ack_pulse_in,
   input  wire logic  vector_pulse_in,
   input  wire logic  fall_pulse_in,
   output logic       request_out,
   output logic [7:0] vec_cnt_out,
   output logic [7:0] fall_cnt_out
);
   // a request not acknowledged stays pending, so it can wake again
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         request_out <= 1'b0;
      else if (set_in)
         request_out <= 1'b1;
      else if (ack_pulse_in || clr_in)
         request_out <= 1'b0;
   end
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         vec_cnt_out  <= 8'h00;
         fall_cnt_out <= 8'h00;
      end
      else
      begin
         vec_cnt_out  <= vec_cnt_out + 8'(vector_pulse_in);
         fall_cnt_out <= fall_cnt_out + 8'(fall_pulse_in);
      end
   end
endmodule

// [dv/disc_standby_properties.sv]
`timescale 1ns/1ps
module disc_standby_properties
   import disc_pkg::*;
#(
   parameter int STAB_BASE_SHIFT = 10
) (
   input wire logic                    clk_in,
   input wire logic                    sys_rst_in,
   input wire logic                    wb_cyc_in,
   input wire logic                    wb_stb_in,
   input wire logic                    wb_ack_out,
   input wire disc_pkg::disc_gate_type gate_out,
   input wire disc_pkg::disc_hold_type hold_out,
   input wire logic                    device_reset_out,
   input wire logic                    vector_pulse_out,
   input wire logic                    ack_pulse_out,
   input wire logic                    fall_through_pulse_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   a_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("bus ack missing");
   a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("bus ack too long");
   a_deep_halts: assert property (gate_out.osc && !gate_out.cpu && !gate_out.pll |-> !gate_out.dma
      && !gate_out.gen_timers && !gate_out.capture_timer && !gate_out.i2c && !gate_out.crc)
      else $error("peripheral clock in deep idle");
   a_entry_holds: assert property ($fell(gate_out.cpu) && gate_out.osc && !gate_out.pll && !device_reset_out
      |-> hold_out.port_hold && hold_out.rto_hold && hold_out.adc_freeze && hold_out.dac_hold
      && hold_out.key_return_active)
      else $error("holds missing on entry");
   a_resume_excl: assert property (vector_pulse_out |-> !fall_through_pulse_out)
      else $error("vector and fall through together");
   a_ack_vectors: assert property (ack_pulse_out |-> vector_pulse_out)
      else $error("ack without vector");
   a_pulse_once: assert property (vector_pulse_out || fall_through_pulse_out
      |=> !vector_pulse_out && !fall_through_pulse_out)
      else $error("resume pulse too long");
   a_reset_gated: assert property (device_reset_out |-> !gate_out.cpu && !gate_out.dma)
      else $error("clock during reset");
   a_cpu_on_osc: assert property ($rose(gate_out.cpu) |-> gate_out.osc && $past(gate_out.osc))
      else $error("cpu clock without oscillator");
endmodule
bind disc_standby disc_standby_properties #(.STAB_BASE_SHIFT(STAB_BASE_SHIFT)) u_props (.clk_in(clk_in),
   .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
   .gate_out(gate_out), .hold_out(hold_out), .device_reset_out(device_reset_out),
   .vector_pulse_out(vector_pulse_out), .ack_pulse_out(ack_pulse_out),
   .fall_through_pulse_out(fall_through_pulse_out));

// [dv/test_disc_standby.sv]
`timescale 1ns/1ps
module test_disc_standby;
   import disc_pkg::*;
   logic          clk_in, sys_rst_in, cyc, stb, we, ack, nmi, rpin, ireq, svc, ei, vec, ackp, fall, dres, setr, clrr;
   logic          wnmi, wrst;
   logic [7:0]    adr, ext, vcnt, fcnt;
   logic [31:0]   wdat, rdat, q;
   logic [2:0]    rp, sp;
   disc_gate_type gate;
   disc_hold_type hold;
   int            miscompares, check_count, n;
   disc_standby #(.STAB_BASE_SHIFT(2)) uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .nmi_pin_in(nmi), .watchdog_nonmaskable_request_in(wnmi), .external_request_pins_in(ext),
      .reset_pin_in(rpin), .watchdog_reset_request_in(wrst), .low_voltage_detector_in(1'b0),
      .clock_monitor_in(1'b0), .internal_request_in(ireq), .request_priority_in(rp), .in_service_in(svc),
      .service_priority_in(sp), .int_enable_in(ei), .option_stab_select_in(3'h0), .gate_out(gate),
      .hold_out(hold), .device_reset_out(dres), .vector_pulse_out(vec), .ack_pulse_out(ackp),
      .fall_through_pulse_out(fall));
   disc_cpu_model cpu (.clk_in(clk_in), .rst_in(sys_rst_in), .set_in(setr), .clr_in(clrr), .ack_pulse_in(ackp),
      .vector_pulse_in(vec), .fall_pulse_in(fall), .request_out(ireq), .vec_cnt_out(vcnt), .fall_cnt_out(fcnt));
   initial
   begin
      clk_in = 0;
      forever #5 clk_in = ~clk_in;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_in);
      while (ack !== 1'b1)
         @(posedge clk_in);
      q = rdat;
      cyc <= 0;
      stb <= 0;
      we <= 0;
      @(posedge clk_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic strobe(input logic s);
      if (s) setr <= 1;
      else clrr <= 1;
      @(posedge clk_in);
      if (s) setr <= 0;
      else clrr <= 0;
   endtask
   task automatic trig(input logic [7:0] m, input logic [7:0] c);
      wb(1, DISC_MODE_OFS, {24'h0, m});
      wb(1, DISC_CTRL_OFS, {24'h0, c});
      repeat (5) @(posedge clk_in);
   endtask
   task automatic wt;
      n = 0;
      while (gate.cpu !== 1'b1 && n < 400)
      begin
         @(posedge clk_in);
         n++;
      end
      chk(32'(gate.cpu), 1);
      repeat (3) @(posedge clk_in);
   endtask
   task automatic t_reset;
      wt();
      chk(32'(dres), 0);
      rd(DISC_MODE_OFS, 32'h10);
      rd(DISC_CTRL_OFS, 32'h0);
      rd(DISC_STAB_OFS, 32'h4);
      rd(8'h20, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_deep(input logic pend);
      logic [7:0] v0, f0;
      v0 = vcnt;
      f0 = fcnt;
      ei <= !pend;
      if (!pend) wb(1, DISC_PCFG_OFS, 32'h49);
      if (pend) strobe(1);
      trig(8'h12, 8'h02);
      if (!pend)
      begin
         chk({gate.osc, gate.cpu, gate.pll, gate.flash, gate.dma}, 32'h10);
         chk({gate.interval_timer, gate.clocked_serial, gate.async_serial}, 32'h49);
         chk(32'(hold.adc_freeze && hold.dac_hold && hold.key_return_active), 1);
         wb(0, DISC_STATUS_OFS, 32'h0);
         chk(32'(q[2:0]), 4);
         strobe(1);
      end
      wt();
      if (!pend) chk(32'(n >= 65), 1);
      chk(32'(gate.pll), 1);
      chk({vcnt, fcnt}, {v0 + 8'(!pend), f0 + 8'(pend)});
      strobe(0);
      $display("deep idle test done");
   endtask
   task automatic t_svc;
      logic [7:0] v0;
      svc <= 1;
      sp <= 3'h2;
      ei <= 1;
      for (int p = 2; p >= 1; p--)
      begin
         v0 = vcnt;
         rp <= 3'(p);
         strobe(1);
         trig(8'h12, 8'h02);
         wt();
         chk(32'(vcnt), 32'(v0 + 8'(p == 1)));
         strobe(0);
      end
      svc <= 0;
      $display("service test done");
   endtask
   task automatic t_modes;
      logic [1:0] m[3] = '{2'h0, 2'h1, 2'h3};
      for (int i = 0; i < 3; i++)
      begin
         trig({6'h4, m[i]}, 8'h02);
         wb(0, DISC_STATUS_OFS, 32'h0);
         chk(32'(q[2:0]), (i == 0) ? 3 : 5);
         chk(32'(gate.osc), (i == 0) ? 1 : 0);
         if (i == 0) ext <= 8'h08;
         else if (i == 1) nmi <= 1;
         else wnmi <= 1;
         wt();
         ext <= 0;
         nmi <= 0;
         wnmi <= 0;
      end
      $display("mode test done");
   endtask
   task automatic t_mask;
      strobe(1);
      nmi <= 1;
      trig(8'h12, 8'h72);
      repeat (40) @(posedge clk_in);
      chk(32'(gate.cpu), 0);
      nmi <= 0;
      rpin <= 1;
      repeat (10) @(posedge clk_in);
      chk(32'(dres), 1);
      rpin <= 0;
      strobe(0);
      wt();
      chk(32'(n < 30), 1);
      rd(DISC_MODE_OFS, 32'h10);
      rd(DISC_CTRL_OFS, 32'h0);
      wb(1, DISC_STAB_OFS, 32'h1);
      wrst <= 1;
      repeat (8) @(posedge clk_in);
      chk(32'(dres && !gate.cpu), 1);
      wrst <= 0;
      wt();
      rd(DISC_STAB_OFS, 32'h4);
      $display("mask and reset test done");
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_in);
      miscompares++;
      end_of_test();
   end
   initial
   begin
      {sys_rst_in, cyc, stb, we, nmi, rpin, svc, ei, setr, clrr, wnmi, wrst} = 12'h800;
      {adr, ext, wdat, rp, sp} = '0;
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 0;
      t_reset();
      t_deep(0);
      t_deep(1);
      t_svc();
      t_modes();
      t_mask();
      end_of_test();
   end
endmodule

// [hw/disc_pkg.sv]
package disc_pkg;

   // register byte offsets on the wishbone slave
   localparam logic [7:0] DISC_MODE_OFS    = 8'h00;
   localparam logic [7:0] DISC_CTRL_OFS    = 8'h04;
   localparam logic [7:0] DISC_STAB_OFS    = 8'h08;
   localparam logic [7:0] DISC_PCFG_OFS    = 8'h0C;
   localparam logic [7:0] DISC_STATUS_OFS  = 8'h10;

   // power_save_mode_reg fields
   localparam int DISC_MODE_LOW_BIT  = 0;
   localparam int DISC_MODE_HIGH_BIT = 1;
   localparam int DISC_PLL_ON_BIT    = 4;
   localparam logic [7:0] DISC_MODE_RST = 8'h10;

   // power_save_control_reg fields
   localparam int DISC_TRIGGER_BIT = 1;
   localparam int DISC_NMI0_M_BIT  = 4;
   localparam int DISC_NMI1_M_BIT  = 5;
   localparam int DISC_MASKABLE_REQUEST_MASK_BIT    = 6;
   localparam logic [7:0] DISC_CTRL_RST = 8'h00;

   // stabilization_time_select
   localparam logic [2:0] DISC_STAB_RST = 3'h4;

   // peripheral clock configuration fields
   localparam int DISC_ITM_SEL_LSB  = 0;
   localparam int DISC_SUBCLK_BIT   = 2;
   localparam int DISC_CSI_EXT_LSB  = 3;
   localparam int DISC_UART0_EXT_BIT = 6;
   localparam logic [7:0] DISC_PCFG_RST = 8'h00;

   // interval timer clock choices
   localparam logic [1:0] DISC_ITM_MAIN    = 2'h0;
   localparam logic [1:0] DISC_ITM_OSC_DIV8 = 2'h1;
   localparam logic [1:0] DISC_ITM_SUBCLK  = 2'h2;

   // mode select encodings
   localparam logic [1:0] DISC_SEL_LIGHT = 2'h0;
   localparam logic [1:0] DISC_SEL_DEEP  = 2'h2;

   localparam int DISC_CNT_W  = 20;
   localparam int DISC_PRIO_W = 3;
   localparam int DISC_SYNC_N = 10;

   typedef enum logic [1:0] {
      DISC_CAUSE_NONE,
      DISC_CAUSE_NMI,
      DISC_CAUSE_MASKABLE,
      DISC_CAUSE_RESET
   } disc_cause_type;

   // clock gates toward the rest of the chip, high = clock delivered
   typedef struct packed {
      logic       osc;
      logic       cpu;
      logic       pll;
      logic       flash;
      logic       dma;
      logic       gen_timers;
      logic       capture_timer;
      logic       interval_timer;
      logic       i2c;
      logic       crc;
      logic       intc;
      logic [2:0] clocked_serial;
      logic [2:0] async_serial;
   } disc_gate_type;

   // freeze and hold controls, high = frozen; key_return_active high = key return active
   typedef struct packed {
      logic adc_freeze;
      logic dac_hold;
      logic rto_hold;
      logic port_hold;
      logic cpu_state_hold;
      logic key_return_active;
   } disc_hold_type;

endpackage

// [hw/disc_standby.sv]
// Operation
// - deep idle entered from normal operation by mode 10 plus trigger bit 1
// - mode 00 plus trigger selects light idle instead
// - mode 01 or 11 plus trigger selects stop, oscillator halts
// - deep idle keeps oscillator, gates cpu, pll, flash and peripherals
// - subclock or external clock peripherals keep running, execution stops
// - cpu state and ram held unchanged across deep idle
// - a pending unmasked request at trigger ends deep idle at once
// - nmi pin, watchdog nmi, unmasked external, internal request or reset end it
// - pll returns to its pre-entry state on exit
// - from a service routine, equal or lower request wakes but stays pending
// - from a service routine, higher or nonmaskable request wakes and is acknowledged
// - a request masked by its mask bit set to 1 never wakes
// - after setup, nmi vectors; maskable vectors or falls through per enable
// - a reset source runs the same sequence as a normal reset
// - interrupt wake starts setup timer per selection, resume on overflow
// - reset wake uses the option byte stabilization setting
// - dma, timers, i2c, crc halt; interrupt controller only keeps wake path
// - interval timer runs only on internal oscillator div 8 or subclock
// - serial channels run only on external clock; uart0 only, others stop
// - a/d freezes keeping result, d/a freezes holding output
// - ports hold, realtime output stops held, key return stays active
`timescale 1ns/1ps
module disc_standby #(
   parameter int STAB_BASE_SHIFT = 10
) (
   input  wire logic                              clk_in,
   input  wire logic                              sys_rst_in,
   input  wire logic                              wb_cyc_in,
   input  wire logic                              wb_stb_in,
   input  wire logic                              wb_we_in,
   input  wire logic [7:0]                        wb_adr_in,
   input  wire logic [3:0]                        wb_sel_in,
   input  wire logic [31:0]                       wb_dat_in,
   output logic [31:0]                            wb_dat_out,
   output logic                                   wb_ack_out,
   input  wire logic                              nmi_pin_in,
   input  wire logic                              watchdog_nonmaskable_request_in,
   input  wire logic [7:0]                        external_request_pins_in,
   input  wire logic                              reset_pin_in,
   input  wire logic                              watchdog_reset_request_in,
   input  wire logic                              low_voltage_detector_in,
   input  wire logic                              clock_monitor_in,
   input  wire logic                              internal_request_in,
   input  wire logic [disc_pkg::DISC_PRIO_W-1:0]  request_priority_in,
   input  wire logic                              in_service_in,
   input  wire logic [disc_pkg::DISC_PRIO_W-1:0]  service_priority_in,
   input  wire logic                              int_enable_in,
   input  wire logic [2:0]                        option_stab_select_in,
   output disc_pkg::disc_gate_type                gate_out,
   output disc_pkg::disc_hold_type                hold_out,
   output logic                                   device_reset_out,
   output logic                                   vector_pulse_out,
   output logic                                   ack_pulse_out,
   output logic                                   fall_through_pulse_out
);
   import disc_pkg::*;

   typedef enum logic [2:0] {
      ST_RST_LOAD,
      ST_RST_SETUP,
      ST_NORMAL,
      ST_LIGHT,
      ST_DEEP,
      ST_STOP,
      ST_SETUP,
      ST_RESUME
   } disc_state_type;

   disc_state_type                state_reg;
   logic [7:0]                    mode_reg;
   logic [7:0]                    ctrl_reg;
   logic [2:0]                    stab_reg;
   logic [7:0]                    pcfg_reg;
   logic [DISC_CNT_W-1:0]         cnt_reg;
   logic                          ovf_reg;
   disc_cause_type                cause_reg;
   logic                          higher_reg;
   logic                          nmi_wake_reg;
   logic                          ack_reg;
   logic [31:0]                   rdata_next;
   logic                          trig_pulse;
   logic [DISC_SYNC_N-1:0]        sync1_reg;
   logic [DISC_SYNC_N-1:0]        sync2_reg;
   logic [DISC_SYNC_N-1:0]        sync3_reg;
   logic [DISC_SYNC_N-1:0]        pin_reg;
   logic                          nmi_req;
   logic                          mask_req;
   logic                          wake_req;
   logic                          rst_req;
   logic                          higher_req;
   logic                          deep_like;
   logic                          idle_any;
   logic                          rst_seq;

   // time of 2^(base+sel) oscillator cycles; base shortens in simulation
   function automatic logic [DISC_CNT_W-1:0] stab_cycles(input logic [2:0] sel);
      logic [DISC_CNT_W-1:0] one;
      one = {{(DISC_CNT_W-1){1'b0}}, 1'b1};
      stab_cycles = one << (STAB_BASE_SHIFT + int'(sel));
   endfunction

   // pins cross in through three flops; a level counts once stages two and three agree
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         pin_reg   <= '0;
      end
      else
      begin
         sync1_reg <= {clock_monitor_in, low_voltage_detector_in, watchdog_reset_request_in,
                       reset_pin_in, (|external_request_pins_in), watchdog_nonmaskable_request_in,
                       nmi_pin_in, 3'h0};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         for (int i = 0; i < DISC_SYNC_N; i++)
         begin
            if (sync2_reg[i] == sync3_reg[i])
            begin
               pin_reg[i] <= sync3_reg[i];
            end
         end
      end
   end

   // masked sources are simply invisible to the wake logic
   always_comb
   begin
      nmi_req  = (pin_reg[3] & ~ctrl_reg[DISC_NMI0_M_BIT])
               | (pin_reg[4] & ~ctrl_reg[DISC_NMI1_M_BIT]);
      mask_req = (pin_reg[5] | internal_request_in) & ~ctrl_reg[DISC_MASKABLE_REQUEST_MASK_BIT];
      wake_req = nmi_req | mask_req;
      rst_req  = |pin_reg[9:6];
      // smaller number is the more urgent level
      higher_req = nmi_req | ~in_service_in
                 | (request_priority_in < service_priority_in);
      trig_pulse = wb_cyc_in & wb_stb_in & wb_we_in & ack_reg & wb_sel_in[0]
                 & (wb_adr_in == DISC_CTRL_OFS) & wb_dat_in[DISC_TRIGGER_BIT];
   end

   // wishbone: ack one cycle after the strobe, dropped the next; write lands on the ack edge
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         ack_reg    <= 1'b0;
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end
      else
      begin
         ack_reg    <= wb_cyc_in & wb_stb_in & ~ack_reg;
         wb_ack_out <= wb_cyc_in & wb_stb_in & ~ack_reg;
         wb_dat_out <= rdata_next;
      end
   end

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      case (wb_adr_in)
         DISC_MODE_OFS:   rdata_next[7:0] = mode_reg;
         DISC_CTRL_OFS:   rdata_next[7:0] = ctrl_reg;
         DISC_STAB_OFS:   rdata_next[2:0] = stab_reg;
         DISC_PCFG_OFS:   rdata_next[7:0] = pcfg_reg;
         DISC_STATUS_OFS: rdata_next[7:0] = {2'h0, cause_reg, 1'b0, state_reg};
         default:         rdata_next = 32'h0000_0000;
      endcase
   end

   // registers return to defaults on any reset source, like a power-on reset
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         mode_reg <= DISC_MODE_RST;
         ctrl_reg <= DISC_CTRL_RST;
         stab_reg <= DISC_STAB_RST;
         pcfg_reg <= DISC_PCFG_RST;
      end
      else if (rst_req)
      begin
         mode_reg <= DISC_MODE_RST;
         ctrl_reg <= DISC_CTRL_RST;
         stab_reg <= DISC_STAB_RST;
         pcfg_reg <= DISC_PCFG_RST;
      end
      else if (wb_cyc_in & wb_stb_in & wb_we_in & ack_reg & wb_sel_in[0])
      begin
         case (wb_adr_in)
            DISC_MODE_OFS: mode_reg <= wb_dat_in[7:0] & 8'h13;
            // trigger is a strobe, it never stays set
            DISC_CTRL_OFS: ctrl_reg <= wb_dat_in[7:0] & 8'h70;
            DISC_STAB_OFS: stab_reg <= wb_dat_in[2:0];
            DISC_PCFG_OFS: pcfg_reg <= wb_dat_in[7:0] & 8'h7F;
            default:       ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // main standby sequencer
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_reg <= ST_RST_LOAD;
         cnt_reg   <= '0;
         ovf_reg   <= 1'b0;
      end
      else if (rst_req)
      begin
         state_reg <= ST_RST_LOAD;
         cnt_reg   <= '0;
         ovf_reg   <= 1'b0;
      end
      else
      begin
         case (state_reg)
            ST_RST_LOAD:
            begin
               cnt_reg   <= stab_cycles(option_stab_select_in);
               ovf_reg   <= 1'b0;
               state_reg <= ST_RST_SETUP;
            end
            ST_RST_SETUP, ST_SETUP:
            begin
               // counts on the oscillator, which never stops in deep idle
               if (cnt_reg == '0)
               begin
                  ovf_reg   <= 1'b1;
                  state_reg <= (state_reg == ST_SETUP) ? ST_RESUME : ST_NORMAL;
               end
               else
                  cnt_reg <= cnt_reg - 1'b1;
            end
            ST_NORMAL:
            begin
               ovf_reg <= 1'b0;
               if (trig_pulse)
               begin
                  if (mode_reg[1:0] == DISC_SEL_LIGHT)
                     state_reg <= ST_LIGHT;
                  else if (mode_reg[1:0] == DISC_SEL_DEEP)
                     state_reg <= ST_DEEP;
                  else
                     state_reg <= ST_STOP;
               end
            end
            ST_LIGHT:
            begin
               // oscillator and pll stayed up, no setup wait needed
               if (wake_req)
                  state_reg <= ST_RESUME;
            end
            ST_DEEP, ST_STOP:
            begin
               // a request already pending wakes on the first cycle here
               if (wake_req)
               begin
                  cnt_reg   <= stab_cycles(stab_reg);
                  ovf_reg   <= 1'b0;
                  state_reg <= ST_SETUP;
               end
            end
            ST_RESUME:
            begin
               ovf_reg   <= 1'b0;
               state_reg <= ST_NORMAL;
            end
            default: state_reg <= ST_RST_LOAD;
         endcase
      end
   end

   // capture what woke us and how it ranks against the routine in service
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         cause_reg    <= DISC_CAUSE_RESET;
         higher_reg   <= 1'b0;
         nmi_wake_reg <= 1'b0;
      end
      else if (rst_req)
      begin
         cause_reg    <= DISC_CAUSE_RESET;
         higher_reg   <= 1'b0;
         nmi_wake_reg <= 1'b0;
      end
      else if ((state_reg == ST_DEEP || state_reg == ST_STOP || state_reg == ST_LIGHT) && wake_req)
      begin
         cause_reg    <= nmi_req ? DISC_CAUSE_NMI : DISC_CAUSE_MASKABLE;
         higher_reg   <= higher_req;
         nmi_wake_reg <= nmi_req;
      end
   end

   // what the cpu does on resume; lower or equal requests stay pending in the controller
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         vector_pulse_out       <= 1'b0;
         ack_pulse_out          <= 1'b0;
         fall_through_pulse_out <= 1'b0;
      end
      else
      begin
         vector_pulse_out       <= 1'b0;
         ack_pulse_out          <= 1'b0;
         fall_through_pulse_out <= 1'b0;
         if (state_reg == ST_RESUME && !rst_req)
         begin
            if (nmi_wake_reg || (int_enable_in && higher_reg))
            begin
               vector_pulse_out <= 1'b1;
               ack_pulse_out    <= 1'b1;
            end
            else
               fall_through_pulse_out <= 1'b1;
         end
      end
   end

   always_comb
   begin
      deep_like = (state_reg == ST_DEEP) || (state_reg == ST_STOP) || (state_reg == ST_SETUP);
      idle_any  = deep_like || (state_reg == ST_LIGHT);
      // a reset source cuts the cpu, dma, general and capture timer, i2c and crc clocks on its first cycle
      rst_seq   = (state_reg == ST_RST_LOAD) || (state_reg == ST_RST_SETUP) || rst_req;
   end

   // clock gates; after deep idle, stop or reset the cpu only gets its clock back once the overflow has been registered
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         gate_out <= '0;
         gate_out.osc <= 1'b1;
         device_reset_out <= 1'b1;
      end
      else
      begin
         device_reset_out <= rst_seq;
         gate_out.osc   <= (state_reg != ST_STOP);
         gate_out.cpu   <= !idle_any && !rst_seq;
         gate_out.pll   <= deep_like ? 1'b0 : mode_reg[DISC_PLL_ON_BIT];
         gate_out.flash <= !deep_like;
         gate_out.dma           <= !idle_any && !rst_seq;
         gate_out.gen_timers    <= !idle_any && !rst_seq;
         gate_out.capture_timer <= !idle_any && !rst_seq;
         gate_out.i2c           <= !idle_any && !rst_seq;
         gate_out.crc           <= !idle_any && !rst_seq;
         // the controller's wake path sits here, outside the gated domain
         gate_out.intc          <= !idle_any;
         gate_out.interval_timer <= !idle_any
            || pcfg_reg[DISC_ITM_SEL_LSB +: 2] == DISC_ITM_OSC_DIV8
            || (pcfg_reg[DISC_SUBCLK_BIT]
                && pcfg_reg[DISC_ITM_SEL_LSB +: 2] == DISC_ITM_SUBCLK);
         for (int i = 0; i < 3; i++)
         begin
            gate_out.clocked_serial[i] <= !idle_any || pcfg_reg[DISC_CSI_EXT_LSB + i];
         end
         gate_out.async_serial[0] <= !idle_any || pcfg_reg[DISC_UART0_EXT_BIT];
         gate_out.async_serial[2:1] <= {2{!idle_any}};
      end
   end

   // holds: state is frozen, never cleared, so everything survives the stay
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         hold_out <= '0;
         hold_out.key_return_active <= 1'b1;
      end
      else
      begin
         hold_out.cpu_state_hold    <= idle_any;
         hold_out.adc_freeze        <= idle_any;
         hold_out.dac_hold          <= idle_any;
         hold_out.rto_hold          <= idle_any;
         hold_out.port_hold         <= idle_any;
         hold_out.key_return_active <= 1'b1;
      end
   end

endmodule
